// >>> core/tmk_pkg.sv
// Shared constants and types for the trigger-mark and aperture-delay control block.
package tmk_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 12;
    localparam int PIPE_DEPTH = 4;
    localparam int SYNC_DEPTH = 2;
    localparam int LAT = PIPE_DEPTH + 1;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DELAY = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;

    localparam int CTRL_MARK_EN = 0;
    localparam int CTRL_SINGLE = 1;
    localparam int CTRL_EIGHT = 2;
    localparam int CTRL_DECIM = 3;
    localparam int CTRL_LCM_LSB = 4;
    localparam int DLY_INV = 0;
    localparam int DLY_COARSE_LSB = 8;
    localparam int DLY_FINE_LSB = 16;
    localparam int DLY_RAMP_EN = 24;
    localparam int DLY_RAMP_FAST = 25;
    localparam int STAT_COARSE_LSB = 0;
    localparam int STAT_BUSY = 8;
    localparam int STAT_TRIG = 9;

    localparam logic [7:0] RST_COARSE = 8'h00;
    localparam logic [7:0] RST_FINE = 8'h00;
    localparam logic [3:0] RST_LCM = 4'h0;

    localparam int RAMP_PERIOD = 256;
    localparam logic [7:0] RAMP_LAST = 8'(RAMP_PERIOD - 1);
    localparam logic [7:0] RAMP_STEP_SLOW = 8'h01;
    localparam logic [7:0] RAMP_STEP_FAST = 8'h04;

    typedef struct packed {
        logic inv;
        logic [7:0] coarse;
        logic [7:0] fine;
    } tmk_delay_t;

    typedef struct packed {
        logic [11:0] rise;
        logic [11:0] fall;
    } tmk_pair_t;

    typedef struct packed {
        logic mark_en;
        logic single;
        logic eight;
        logic decim;
    } tmk_mode_t;

    typedef enum logic [0:0] {
        TMK_RAMP_IDLE = 1'b0,
        TMK_RAMP_RUN = 1'b1
    } tmk_ramp_state_t;
endpackage : tmk_pkg

// >>> core/tmk_delay_line.sv
// Fixed-depth register pipeline used to keep parallel paths at equal latency.
`timescale 1ns/1ns
module tmk_delay_line #(
    parameter int W = 1,
    parameter int D = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [D-1:0][W-1:0] taps;
    } tmk_line_t;

    tmk_line_t q;
    tmk_line_t next_q;

    always_comb begin
        next_q = q;
        next_q.taps[0] = din;
        for (int i = 1; i < D; i++) begin
            next_q.taps[i] = q.taps[i-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.taps[D-1];
endmodule : tmk_delay_line

// >>> core/tmk_coarse_ramp.sv
// Coarse delay setter that either jumps or walks toward a newly written value.
`timescale 1ns/1ns
module tmk_coarse_ramp (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [7:0] target,
    input wire logic ramp_en,
    input wire logic fast,
    output logic [7:0] coarse,
    output logic busy
);
    typedef struct packed {
        tmk_pkg::tmk_ramp_state_t st;
        logic [7:0] tgt;
        logic [7:0] cur;
        logic [7:0] tick;
    } tmk_ramp_t;

    tmk_ramp_t q;
    tmk_ramp_t next_q;
    logic [7:0] step;

    // A whole step is never allowed to overshoot the goal.
    always_comb begin
        next_q = q;
        step = fast ? tmk_pkg::RAMP_STEP_FAST : tmk_pkg::RAMP_STEP_SLOW;
        next_q.tick = q.tick + 8'h01;
        if (load) begin
            next_q.tgt = target;
            next_q.tick = 8'h00;
            if (ramp_en) begin
                next_q.st = tmk_pkg::TMK_RAMP_RUN;
            end else begin
                next_q.cur = target;
                next_q.st = tmk_pkg::TMK_RAMP_IDLE;
            end
        end else if (q.st == tmk_pkg::TMK_RAMP_RUN) begin
            if (q.cur == q.tgt) begin
                next_q.st = tmk_pkg::TMK_RAMP_IDLE;
            end else if (q.tick == tmk_pkg::RAMP_LAST) begin
                if (q.cur < q.tgt) begin
                    next_q.cur = (q.tgt - q.cur <= step) ? q.tgt : q.cur + step;
                end else begin
                    next_q.cur = (q.cur - q.tgt <= step) ? q.tgt : q.cur - step;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '{st: tmk_pkg::TMK_RAMP_IDLE, tgt: tmk_pkg::RST_COARSE,
                   cur: tmk_pkg::RST_COARSE, tick: 8'h00};
        end else begin
            q <= next_q;
        end
    end

    assign coarse = q.cur;
    assign busy = (q.st == tmk_pkg::TMK_RAMP_RUN);

    a_ramp_hold_between: assert property (
        @(posedge ref_clk) disable iff (reset)
        (busy && !load && q.tick != tmk_pkg::RAMP_LAST) |=> $stable(coarse)
    ) else $error("Coarse delay moved between ramp ticks.");

    a_ramp_step_taken: assert property (
        @(posedge ref_clk) disable iff (reset)
        (busy && !load && q.tick == tmk_pkg::RAMP_LAST && q.cur != q.tgt)
        |=> coarse != $past(coarse)
    ) else $error("Coarse delay did not step at the ramp tick.");
endmodule : tmk_coarse_ramp

// >>> core/tmk_sample_mark.sv
// Trigger-mark sample formatting and aperture-delay control with an APB register file.
//
// How it works
// - Trigger mark goes out only while the mark enable bit is set.
// - Marked 12-bit samples carry upper 11 data bits plus trigger LSB.
// - Marked 8-bit samples carry the trigger state in their LSB.
// - Trigger path has exactly the converter data pipeline latency.
// - Trigger may be asynchronous; sampled with the data, no handshake.
// - One device clock runs sampling, processing and serial outputs.
// - Dual-channel mode yields one sample per clock, rising edge only.
// - Single-channel mode yields samples on both clock edges.
// - Clock invert bit adds a half-period delay; single setting.
// - Coarse and fine delays are 8-bit, 256 settings each.
// - Invert, coarse and fine act independently and add together.
// - Programmed delay shifts every internal clock, outputs included.
// - Delay changes are taken any time; ramping eases link upsets.
// - With ramp on, coarse moves one or four steps per 256 clocks.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module tmk_sample_mark (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tmk_pkg::tmk_pair_t sample_in,
    input wire logic trigger_mark_input,
    output tmk_pkg::tmk_pair_t sample_out,
    output logic valid_rise,
    output logic valid_fall,
    output tmk_pkg::tmk_delay_t delay_ctrl,
    output logic [3:0] lane_config_mode
);
    typedef struct packed {
        logic [31:0] rdata;
        tmk_pkg::tmk_mode_t mode;
        logic [3:0] lcm;
        logic inv;
        logic [7:0] coarse_tgt;
        logic [7:0] fine;
        logic ramp_en;
        logic ramp_fast;
        logic [1:0] trig_sync;
        tmk_pkg::tmk_pair_t out;
        logic [1:0] vld;
    } tmk_core_t;

    tmk_core_t q;
    tmk_core_t next_q;

    tmk_pkg::tmk_pair_t data_al;
    logic trig_al;
    logic [1:0] vld_al;
    logic [7:0] coarse_cur;
    logic ramp_busy;
    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_delay;
    logic hit_status;
    logic mapped;
    logic wr_ctrl;
    logic wr_delay;
    logic mark_on;

    function automatic logic [11:0] tmk_fmt(
        input logic [11:0] d,
        input logic t,
        input logic m,
        input logic e
    );
        logic [11:0] r;
        r = d;
        if (e) begin
            r = {4'h0, d[11:4]};
            if (m) begin
                r = {4'h0, d[11:5], t};
            end
        end else if (m) begin
            r = {d[11:1], t};
        end
        return r;
    endfunction : tmk_fmt

    // Converter words ride a PIPE_DEPTH-stage line; the synchronised trigger rides two stages, so the total latencies match.
    tmk_delay_line #(
        .W(2 * tmk_pkg::SAMPLE_W),
        .D(tmk_pkg::PIPE_DEPTH)
    ) u_data_line (
        .ref_clk(ref_clk),
        .reset(reset),
        .din(sample_in),
        .dout(data_al)
    );

    // The two synchroniser flops count toward the trigger latency.
    tmk_delay_line #(
        .W(1),
        .D(tmk_pkg::PIPE_DEPTH - tmk_pkg::SYNC_DEPTH)
    ) u_trig_line (
        .ref_clk(ref_clk),
        .reset(reset),
        .din(q.trig_sync[1]),
        .dout(trig_al)
    );

    tmk_delay_line #(
        .W(2),
        .D(tmk_pkg::PIPE_DEPTH)
    ) u_valid_line (
        .ref_clk(ref_clk),
        .reset(reset),
        .din({1'b1, q.mode.single}),
        .dout(vld_al)
    );

    tmk_coarse_ramp u_ramp (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(wr_delay),
        .target(pwdata[tmk_pkg::DLY_COARSE_LSB +: 8]),
        .ramp_en(pwdata[tmk_pkg::DLY_RAMP_EN]),
        .fast(q.ramp_fast),
        .coarse(coarse_cur),
        .busy(ramp_busy)
    );

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_ctrl = (paddr == tmk_pkg::OFF_CTRL);
    assign hit_delay = (paddr == tmk_pkg::OFF_DELAY);
    assign hit_status = (paddr == tmk_pkg::OFF_STATUS);
    assign mapped = hit_ctrl || hit_delay || hit_status;
    assign wr_ctrl = access_ph && pwrite && hit_ctrl;
    // Delay writes are taken at any time, even while samples stream.
    assign wr_delay = access_ph && pwrite && hit_delay;
    // Marking is held off in decimating modes, where the LSB carries other data.
    assign mark_on = q.mode.mark_en && !q.mode.decim;

    always_comb begin
        next_q = q;
        // Only the second flop is read; a plain sample suffices, no handshake.
        next_q.trig_sync = {q.trig_sync[0], trigger_mark_input};
        next_q.out.rise = tmk_fmt(data_al.rise, trig_al, mark_on, q.mode.eight);
        next_q.out.fall = 12'h000;
        if (vld_al[0]) begin
            next_q.out.fall = tmk_fmt(data_al.fall, trig_al, mark_on, q.mode.eight);
        end
        next_q.vld = vld_al;
        if (setup_ph && !pwrite) begin
            next_q.rdata = 32'h0000_0000;
            if (hit_ctrl) begin
                next_q.rdata[tmk_pkg::CTRL_MARK_EN] = q.mode.mark_en;
                next_q.rdata[tmk_pkg::CTRL_SINGLE] = q.mode.single;
                next_q.rdata[tmk_pkg::CTRL_EIGHT] = q.mode.eight;
                next_q.rdata[tmk_pkg::CTRL_DECIM] = q.mode.decim;
                next_q.rdata[tmk_pkg::CTRL_LCM_LSB +: 4] = q.lcm;
            end else if (hit_delay) begin
                next_q.rdata[tmk_pkg::DLY_INV] = q.inv;
                next_q.rdata[tmk_pkg::DLY_COARSE_LSB +: 8] = q.coarse_tgt;
                next_q.rdata[tmk_pkg::DLY_FINE_LSB +: 8] = q.fine;
                next_q.rdata[tmk_pkg::DLY_RAMP_EN] = q.ramp_en;
                next_q.rdata[tmk_pkg::DLY_RAMP_FAST] = q.ramp_fast;
            end else if (hit_status) begin
                next_q.rdata[tmk_pkg::STAT_COARSE_LSB +: 8] = coarse_cur;
                next_q.rdata[tmk_pkg::STAT_BUSY] = ramp_busy;
                next_q.rdata[tmk_pkg::STAT_TRIG] = q.trig_sync[1];
            end
        end
        if (wr_ctrl) begin
            next_q.mode.mark_en = pwdata[tmk_pkg::CTRL_MARK_EN];
            next_q.mode.single = pwdata[tmk_pkg::CTRL_SINGLE];
            next_q.mode.eight = pwdata[tmk_pkg::CTRL_EIGHT];
            next_q.mode.decim = pwdata[tmk_pkg::CTRL_DECIM];
            next_q.lcm = pwdata[tmk_pkg::CTRL_LCM_LSB +: 4];
        end
        if (wr_delay) begin
            next_q.inv = pwdata[tmk_pkg::DLY_INV];
            next_q.coarse_tgt = pwdata[tmk_pkg::DLY_COARSE_LSB +: 8];
            next_q.fine = pwdata[tmk_pkg::DLY_FINE_LSB +: 8];
            next_q.ramp_en = pwdata[tmk_pkg::DLY_RAMP_EN];
            next_q.ramp_fast = pwdata[tmk_pkg::DLY_RAMP_FAST];
        end
    end

    // Everything here runs on the one device clock, so no internal crossings exist.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.coarse_tgt <= tmk_pkg::RST_COARSE;
            q.fine <= tmk_pkg::RST_FINE;
            q.lcm <= tmk_pkg::RST_LCM;
        end else begin
            q <= next_q;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign sample_out = q.out;
    assign valid_rise = q.vld[1];
    assign valid_fall = q.vld[0];
    assign lane_config_mode = q.lcm;
    // The three settings leave as one word to the clock-root delay, so every
    // derived clock, serial outputs and reference capture shift together.
    assign delay_ctrl.inv = q.inv;
    assign delay_ctrl.coarse = coarse_cur;
    assign delay_ctrl.fine = q.fine;

    a_mark_lsb_twelve: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(mark_on && !q.mode.eight)
        |-> sample_out.rise == {$past(data_al.rise[11:1]), $past(trig_al)}
    ) else $error("Marked 12-bit sample is not upper data with trigger LSB.");

    a_mark_lsb_eight: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(mark_on && q.mode.eight)
        |-> sample_out.rise == {4'h0, $past(data_al.rise[11:5]), $past(trig_al)}
    ) else $error("Marked 8-bit sample does not carry the trigger LSB.");

    a_full_result_out: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(!mark_on && !q.mode.eight) |-> sample_out.rise == $past(data_al.rise)
    ) else $error("Unmarked sample lost its own LSB.");

    a_mark_off_decim: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(q.mode.decim && !q.mode.eight)
        |-> sample_out.rise == $past(data_al.rise)
    ) else $error("Trigger mark appeared while marking is not allowed.");

    a_trig_latency_match: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!$past(reset, tmk_pkg::LAT) && $past(mark_on && !q.mode.eight))
        |-> sample_out.rise[0] == $past(trigger_mark_input, tmk_pkg::LAT)
    ) else $error("Trigger bit latency differs from the data latency.");

    a_data_latency_fixed: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!$past(reset, tmk_pkg::LAT) && $past(!q.mode.eight))
        |-> sample_out.rise[11:1] == $past(sample_in.rise[11:1], tmk_pkg::LAT)
    ) else $error("Converter data latency is wrong.");

    a_dual_rise_only: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!$past(reset, tmk_pkg::LAT) && $past(!q.mode.single, tmk_pkg::LAT))
        |-> valid_rise && !valid_fall && sample_out.fall == 12'h000
    ) else $error("Dual-channel mode produced a falling-edge sample.");

    a_single_both_edges: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!$past(reset, tmk_pkg::LAT) && $past(q.mode.single, tmk_pkg::LAT)
            && $past(!q.mode.eight))
        |-> valid_rise && valid_fall
            && sample_out.fall[11:1] == $past(sample_in.fall[11:1], tmk_pkg::LAT)
    ) else $error("Single-channel mode lost the falling-edge sample.");

    a_delay_write_apply: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_delay |=> delay_ctrl.inv == $past(pwdata[tmk_pkg::DLY_INV])
            && delay_ctrl.fine == $past(pwdata[tmk_pkg::DLY_FINE_LSB +: 8])
    ) else $error("Invert or fine delay not applied after the write.");

    a_coarse_direct_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        (wr_delay && !pwdata[tmk_pkg::DLY_RAMP_EN])
        |=> delay_ctrl.coarse == $past(pwdata[tmk_pkg::DLY_COARSE_LSB +: 8]) && !ramp_busy
    ) else $error("Coarse delay not set at once with ramping off.");

    a_delay_independent: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!wr_delay && !ramp_busy) |=> $stable(delay_ctrl)
    ) else $error("A delay setting moved without a write or ramp.");

    a_ramp_gradual: assert property (
        @(posedge ref_clk) disable iff (reset)
        (wr_delay && pwdata[tmk_pkg::DLY_RAMP_EN]
            && pwdata[tmk_pkg::DLY_COARSE_LSB +: 8] != coarse_cur)
        |=> ramp_busy && $stable(delay_ctrl.coarse)
    ) else $error("Ramped coarse write jumped instead of walking.");

    a_unmapped_error: assert property (
        @(posedge ref_clk) disable iff (reset)
        (setup_ph && !pwrite && !mapped) |=> prdata == 32'h0000_0000
    ) else $error("Unmapped read returned nonzero data.");

    // An unmarked 8-bit sample is the top of the converter word.
    a_eight_unmarked: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(!mark_on && q.mode.eight)
        |-> sample_out.rise == {4'h0, $past(data_al.rise[11:4])}
    ) else $error("Unmarked 8-bit sample is not the upper bits.");

    a_fall_mark_twelve: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(mark_on && !q.mode.eight && vld_al[0])
        |-> sample_out.fall == {$past(data_al.fall[11:1]), $past(trig_al)}
    ) else $error("Marked falling sample lost the trigger LSB.");

    a_fall_mark_eight: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(mark_on && q.mode.eight && vld_al[0])
        |-> sample_out.fall == {4'h0, $past(data_al.fall[11:5]), $past(trig_al)}
    ) else $error("Marked 8-bit falling sample lost the trigger LSB.");

    // Two plain flops and no acknowledge, so a trigger is never held back.
    a_trig_two_flops: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!$past(reset) && !$past(reset, 2))
        |-> q.trig_sync[1] == $past(trigger_mark_input, 2)
    ) else $error("Trigger synchroniser is not two flops deep.");

    a_valid_after_fill: assert property (
        @(posedge ref_clk) disable iff (reset)
        !$past(reset, tmk_pkg::LAT) |-> valid_rise
    ) else $error("Rising-edge sample missing after the pipeline filled.");

    a_ctrl_write_apply: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_ctrl |=> q.mode.mark_en == $past(pwdata[tmk_pkg::CTRL_MARK_EN])
            && lane_config_mode == $past(pwdata[tmk_pkg::CTRL_LCM_LSB +: 4])
    ) else $error("Control write was not applied.");

    a_ramp_keeps_rest: assert property (
        @(posedge ref_clk) disable iff (reset)
        !wr_delay |=> $stable(delay_ctrl.inv) && $stable(delay_ctrl.fine)
    ) else $error("Invert or fine delay moved without a delay write.");

    a_ramp_no_overshoot: assert property (
        @(posedge ref_clk) disable iff (reset)
        (ramp_busy && !wr_delay && coarse_cur <= q.coarse_tgt)
        |=> delay_ctrl.coarse <= $past(q.coarse_tgt)
    ) else $error("Rising ramp passed its target.");

    // The rate comes from the stored setting, so later bus traffic cannot alter it.
    a_ramp_slow_step: assert property (
        @(posedge ref_clk) disable iff (reset)
        (ramp_busy && !wr_delay && !q.ramp_fast)
        |=> $stable(delay_ctrl.coarse)
            || delay_ctrl.coarse == $past(coarse_cur) + tmk_pkg::RAMP_STEP_SLOW
            || delay_ctrl.coarse == $past(coarse_cur) - tmk_pkg::RAMP_STEP_SLOW
    ) else $error("Slow ramp step is not one.");

    a_ramp_fast_step: assert property (
        @(posedge ref_clk) disable iff (reset)
        (ramp_busy && !wr_delay && q.ramp_fast)
        |=> $stable(delay_ctrl.coarse) || delay_ctrl.coarse == $past(q.coarse_tgt)
            || delay_ctrl.coarse == $past(coarse_cur) + tmk_pkg::RAMP_STEP_FAST
            || delay_ctrl.coarse == $past(coarse_cur) - tmk_pkg::RAMP_STEP_FAST
    ) else $error("Fast ramp step is not four.");
endmodule : tmk_sample_mark

// >>> tb/tmk_source_model.sv
// Behavioural converter and trigger source that feeds the sample path.
`timescale 1ns/1ns
module tmk_source_model #(
    parameter int MF_CLKS = 40
) (
    input wire logic ref_clk,
    output tmk_pkg::tmk_pair_t sample_in,
    output logic trigger_mark_input
);
    logic [11:0] cnt;
    int mf_cnt;
    initial begin
        cnt = 12'h000;
        mf_cnt = 0;
        sample_in = '0;
        trigger_mark_input = 1'b0;
    end
    // The trigger pattern mixes counter bits 3 and 6 with the multiframe pulse, so any skew between the two paths shows.
    always @(posedge ref_clk) begin
        cnt <= cnt + 12'h025;
        sample_in.rise <= cnt;
        sample_in.fall <= cnt ^ 12'ha5c;
        // A pulse once per multiframe stands in for a periodic reference.
        mf_cnt <= (mf_cnt == MF_CLKS - 1) ? 0 : mf_cnt + 1;
        trigger_mark_input <= cnt[3] ^ cnt[6] ^ (mf_cnt == 0);
    end
endmodule : tmk_source_model

// >>> tb/testbench.sv
// Self-checking bench for the trigger-mark and aperture-delay block.
`timescale 1ns/1ns
module testbench;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, err, trig;
    logic valid_rise, valid_fall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] lane_config_mode;
    tmk_pkg::tmk_pair_t sample_in, sample_out;
    tmk_pkg::tmk_delay_t delay_ctrl;
    tmk_pkg::tmk_pair_t hist_s [16];
    logic hist_t [16];
    int cyc = 0;
    int error_cnt = 0;
    int n_compared = 0;

    tmk_source_model u_src (.ref_clk(ref_clk), .sample_in(sample_in), .trigger_mark_input(trig));
    tmk_sample_mark u_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_in(sample_in), .trigger_mark_input(trig),
        .sample_out(sample_out), .valid_rise(valid_rise), .valid_fall(valid_fall),
        .delay_ctrl(delay_ctrl), .lane_config_mode(lane_config_mode));

    // One clock runs sampling, formatting and the register file alike.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Inputs are recorded as sampled, so expectations never come from the outputs.
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        hist_s[cyc % 16] = sample_in;
        hist_t[cyc % 16] = trig;
        if (cyc > 5000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] fmt(input logic [11:0] d, input logic t, m, e);
        if (e) return m ? {4'h0, d[11:5], t} : {4'h0, d[11:4]};
        return m ? {d[11:1], t} : d;
    endfunction : fmt

    function automatic logic [31:0] dly(input logic i, input logic [7:0] c, f, input logic r, q);
        return {6'h0, q, r, f, c, 7'h0, i};
    endfunction : dly

    task automatic stream(input logic m, s, e, input int n);
        tmk_pkg::tmk_pair_t h;
        logic t;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            h = hist_s[(cyc - 4) % 16];
            t = hist_t[(cyc - 4) % 16];
            chk("rise", 32'(fmt(h.rise, t, m, e)), 32'(sample_out.rise));
            chk("fall", s ? 32'(fmt(h.fall, t, m, e)) : 32'h0, 32'(sample_out.fall));
            chk("valid", {30'h0, 1'b1, s}, {30'h0, valid_rise, valid_fall});
        end
    endtask : stream

    // Waiting past the latency keeps samples taken under the old mode out of the check.
    task automatic set_mode(input logic m, s, e, dc, input logic [3:0] lcm);
        apb(1'b1, tmk_pkg::OFF_CTRL, {24'h0, lcm, dc, e, s, m});
        repeat (tmk_pkg::LAT + 2) @(posedge ref_clk);
        chk("lane_mode", 32'(lcm), 32'(lane_config_mode));
        stream(m & ~dc, s, e, 12);
    endtask : set_mode

    task automatic wait_coarse(input logic [7:0] v, input int n);
        int k;
        logic [7:0] c0;
        k = 0;
        c0 = delay_ctrl.coarse;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (delay_ctrl.coarse === c0 && k < 600);
        chk("coarse", 32'(v), 32'(delay_ctrl.coarse));
        if (n > 0) chk("ramp_gap", n, k);
    endtask : wait_coarse

    task automatic t_reset;
        int k;
        k = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (valid_rise !== 1'b1 && k < 20);
        chk("fill_latency", tmk_pkg::LAT, k);
        chk("delay_rst", 32'h0, 32'(delay_ctrl));
        chk("lane_rst", 32'h0, 32'(lane_config_mode));
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("read", 32'h0, rd & 32'hfffffdff);
            chk("slverr", (a == 12) ? 32'h1 : 32'h0, 32'(err));
        end
        apb(1'b1, tmk_pkg::OFF_STATUS, 32'hffffffff);
        apb(1'b0, tmk_pkg::OFF_STATUS, 32'h0);
        chk("status_ro", 32'h0, rd & 32'hfffffdff);
        $display("reset test done");
    endtask : t_reset

    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            set_mode(i[0], 1'b0, i[1], 1'b0, 4'(i));
        end
        set_mode(1'b1, 1'b1, 1'b0, 1'b0, 4'h5);
        set_mode(1'b1, 1'b1, 1'b1, 1'b0, 4'h6);
        set_mode(1'b0, 1'b0, 1'b0, 1'b1, 4'h9);
        apb(1'b0, tmk_pkg::OFF_CTRL, 32'h0);
        chk("ctrl_read", 32'h98, rd);
        set_mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        $display("mode test done");
    endtask : t_modes

    task automatic t_delay;
        logic [16:0] tab [3];
        tab = '{{1'b1, 8'hff, 8'h00}, {1'b0, 8'h80, 8'hff}, {1'b1, 8'h00, 8'h5a}};
        foreach (tab[i]) begin
            apb(1'b1, tmk_pkg::OFF_DELAY, dly(tab[i][16], tab[i][15:8], tab[i][7:0], 1'b0, 1'b0));
            #1;
            chk("delay_ctrl", 32'(tab[i]), 32'(delay_ctrl));
            stream(1'b0, 1'b0, 1'b0, 3);
        end
        $display("delay test done");
    endtask : t_delay

    task automatic t_ramp;
        apb(1'b1, tmk_pkg::OFF_DELAY, dly(1'b0, 8'h03, 8'h11, 1'b1, 1'b0));
        #1;
        chk("coarse_hold", 32'h0, 32'(delay_ctrl.coarse));
        chk("fine", 32'h11, 32'(delay_ctrl.fine));
        wait_coarse(8'h01, tmk_pkg::RAMP_PERIOD);
        apb(1'b0, tmk_pkg::OFF_STATUS, 32'h0);
        chk("busy", 32'h101, rd & 32'h1ff);
        wait_coarse(8'h02, 0);
        wait_coarse(8'h03, tmk_pkg::RAMP_PERIOD);
        repeat (3) @(posedge ref_clk);
        apb(1'b0, tmk_pkg::OFF_STATUS, 32'h0);
        chk("idle", 32'h003, rd & 32'h1ff);
        apb(1'b1, tmk_pkg::OFF_DELAY, dly(1'b1, 8'h0a, 8'h22, 1'b1, 1'b1));
        // This read spends three edges and clears pwdata; the rate must stay fast.
        apb(1'b0, tmk_pkg::OFF_STATUS, 32'h0);
        chk("busy_fast", 32'h103, rd & 32'h1ff);
        wait_coarse(8'h07, tmk_pkg::RAMP_PERIOD - 3);
        wait_coarse(8'h0a, tmk_pkg::RAMP_PERIOD);
        chk("inv", 32'h1, 32'(delay_ctrl.inv));
        stream(1'b0, 1'b0, 1'b0, 4);
        $display("ramp test done");
    endtask : t_ramp

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        t_reset();
        t_modes();
        t_delay();
        t_ramp();
        tally_and_finish();
    end
endmodule : testbench
